// file: core/status_indirect_pkg.sv
package status_indirect_pkg;
  localparam logic [6:0] status_offset = 7'h03;
  localparam logic [6:0] indirect_location_offset = 7'h00;
  localparam logic [6:0] indirect_pointer_offset = 7'h04;
  localparam int bit_indirect_bank = 7;
  localparam int bit_direct_bank_high = 6;
  localparam int bit_direct_bank_low = 5;
  localparam int bit_timeout = 4;
  localparam int bit_powerdown = 3;
  localparam int bit_zero = 2;
  localparam int bit_digit_carry = 1;
  localparam int bit_carry = 0;
  localparam logic [7:0] status_reset = 8'h18;
  localparam logic [7:0] pointer_reset = 8'h00;
  localparam logic [7:0] arith_flag_mask = 8'h07;
  localparam logic [7:0] event_flag_mask = 8'h18;

  typedef enum logic [3:0] {
    op_none = 4'h1,
    op_add = 4'h2,
    op_sub = 4'h4,
    op_logic = 4'h8
  } alu_op_e;

  typedef struct packed {
    logic wr_en;
    logic [7:0] addr;
    logic [7:0] wdata;
    alu_op_e op;
    logic [7:0] opa;
    logic [7:0] opb;
    logic carry_in_en;
    logic carry_in;
  } core_req_s;

  typedef struct packed {
    logic timeout_set;
    logic timeout_clr;
    logic powerdown_set;
    logic powerdown_clr;
  } dev_event_s;
endpackage

// file: core/status_indirect.sv
// How it works
// - The status register answers at offset 03h in bank 0 and at 83h in bank 1.
// - Add and subtract set carry on a carry out of bit 7 and clear it otherwise.
// - Digit carry follows a carry out of bit 3, and both carries act as inverted borrows (clear on a borrow) in subtraction.
// - Accesses to the indirect location act on the register named by the pointer; it holds nothing itself.
// - Reading the indirect location through a zero pointer returns zero.
// - Writing the indirect location through a zero pointer changes no register, though flags may update.
// - The indirect address is nine bits, indirect bank bit above the 8-bit pointer.
// - A status write from a flag-updating instruction leaves zero, digit carry and carry to the flag logic.
// - Time-out and power-down bits change only on device events, never by instruction writes.
`timescale 1ns/1ps
`default_nettype none
module status_indirect
  import status_indirect_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire core_req_s req,
  input wire dev_event_s dev_event,
  input wire logic [7:0] mem_rdata,
  output logic [8:0] mem_addr,
  output logic mem_sel,
  output logic mem_wr_en,
  output logic [7:0] mem_wdata,
  output logic [7:0] rdata,
  output logic [7:0] alu_result,
  output logic [7:0] status_out,
  output logic [7:0] pointer_out
);

  logic [7:0] status_r, status_nxt;
  logic [7:0] pointer_r, pointer_nxt;
  logic [8:0] eff_addr;
  logic is_indirect, self_ref;
  logic [8:0] sum9;
  logic [4:0] sum5;
  logic [7:0] addend;
  logic cin;
  logic arith;

  ////////////////////////////////////////////////////////////
  // Address formation
  always_comb begin
    is_indirect = (req.addr[6:0] == indirect_location_offset);
    if (is_indirect) begin
      eff_addr = {status_r[bit_indirect_bank], pointer_r};
    end else begin
      eff_addr = {1'b0, status_r[bit_direct_bank_low], req.addr[6:0]};
    end
    self_ref = is_indirect && (eff_addr[6:0] == indirect_location_offset);
  end

  ////////////////////////////////////////////////////////////
  // Adder with borrow polarity for subtract
  always_comb begin
    addend = (req.op == op_sub) ? ~req.opb : req.opb;
    cin = (req.op == op_sub) ? 1'b1 : 1'b0;
    sum9 = {1'b0, req.opa} + {1'b0, addend} + {8'h00, cin};
    sum5 = {1'b0, req.opa[3:0]} + {1'b0, addend[3:0]} + {4'h0, cin};
    arith = (req.op == op_add) || (req.op == op_sub);
    unique case (req.op)
      op_add, op_sub: alu_result = sum9[7:0];
      op_logic: alu_result = req.wdata;
      op_none: alu_result = req.wdata;
      default: alu_result = req.wdata;
    endcase
  end

  ////////////////////////////////////////////////////////////
  // Status and pointer next state
  always_comb begin
    logic st_hit;
    logic ptr_hit;
    logic [7:0] wmask;
    st_hit = 1'b0;
    ptr_hit = 1'b0;
    wmask = 8'hff;
    status_nxt = status_r;
    pointer_nxt = pointer_r;
    st_hit = (eff_addr[6:0] == status_offset) && !self_ref;
    ptr_hit = (eff_addr[6:0] == indirect_pointer_offset) && !self_ref;
    wmask = ~event_flag_mask;
    if (req.op != op_none) begin
      wmask = wmask & ~arith_flag_mask;
    end
    if (req.wr_en && st_hit) begin
      status_nxt = (status_r & ~wmask) | (req.wdata & wmask);
    end
    if (req.wr_en && ptr_hit) begin
      pointer_nxt = req.wdata;
    end
    if (req.op != op_none) begin
      status_nxt[bit_zero] = (alu_result == 8'h00);
    end
    if (arith) begin
      status_nxt[bit_carry] = sum9[8];
      status_nxt[bit_digit_carry] = sum5[4];
    end else if (req.carry_in_en) begin
      status_nxt[bit_carry] = req.carry_in;
    end
    if (dev_event.timeout_clr) status_nxt[bit_timeout] = 1'b0;
    if (dev_event.timeout_set) status_nxt[bit_timeout] = 1'b1;
    if (dev_event.powerdown_clr) status_nxt[bit_powerdown] = 1'b0;
    if (dev_event.powerdown_set) status_nxt[bit_powerdown] = 1'b1;
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      status_r <= status_reset;
      pointer_r <= pointer_reset;
    end else begin
      status_r <= status_nxt;
      pointer_r <= pointer_nxt;
    end
  end

  ////////////////////////////////////////////////////////////
  // Read path and memory port
  always_comb begin
    mem_addr = eff_addr;
    mem_wdata = req.wdata;
    mem_sel = !self_ref && (eff_addr[6:0] != status_offset) && (eff_addr[6:0] != indirect_pointer_offset);
    mem_wr_en = req.wr_en && mem_sel;
    if (self_ref) begin
      rdata = 8'h00;
    end else if (eff_addr[6:0] == status_offset) begin
      rdata = status_r;
    end else if (eff_addr[6:0] == indirect_pointer_offset) begin
      rdata = pointer_r;
    end else begin
      rdata = mem_rdata;
    end
  end

  assign status_out = status_r;
  assign pointer_out = pointer_r;

  ////////////////////////////////////////////////////////////
  // Checks
  // Indirect and direct addressing
  chk_self_read_zero: assert property (@(posedge core_clk) disable iff (!reset_n)
    self_ref
    |-> rdata == 8'h00 && !mem_wr_en)
    else $error("self indirect access leaked");

  chk_self_write_none: assert property (@(posedge core_clk) disable iff (!reset_n)
    (self_ref && req.op == op_none)
    |=> $stable(status_r & ~event_flag_mask) && $stable(pointer_r))
    else $error("self indirect write changed state");

  chk_ind_addr: assert property (@(posedge core_clk) disable iff (!reset_n)
    is_indirect
    |-> mem_addr == {status_r[bit_indirect_bank], pointer_r})
    else $error("indirect address wrong");

  chk_direct_bank: assert property (@(posedge core_clk) disable iff (!reset_n)
    !is_indirect
    |-> mem_addr[7] == status_r[bit_direct_bank_low] && mem_addr[8] == 1'b0)
    else $error("direct bank wrong");

  chk_pointer_write: assert property (@(posedge core_clk) disable iff (!reset_n)
    (req.wr_en && !is_indirect && req.addr[6:0] == indirect_pointer_offset)
    |=> pointer_r == $past(req.wdata))
    else $error("pointer write lost");

  // Arithmetic flags
  chk_carry_add: assert property (@(posedge core_clk) disable iff (!reset_n)
    req.op == op_add
    |=> status_r[bit_carry] == ($past(req.opa) > ~$past(req.opb)))
    else $error("carry wrong");

  chk_borrow_sub: assert property (@(posedge core_clk) disable iff (!reset_n)
    req.op == op_sub
    |=> status_r[bit_carry] == ($past(req.opa) >= $past(req.opb)))
    else $error("borrow wrong");

  chk_dc_add: assert property (@(posedge core_clk) disable iff (!reset_n)
    req.op == op_add
    |=> status_r[bit_digit_carry] == ($past(req.opa[3:0]) > ~$past(req.opb[3:0])))
    else $error("digit carry wrong");

  chk_dc_sub: assert property (@(posedge core_clk) disable iff (!reset_n)
    req.op == op_sub
    |=> status_r[bit_digit_carry] == ($past(req.opa[3:0]) >= $past(req.opb[3:0])))
    else $error("digit borrow wrong");

  chk_zero_add: assert property (@(posedge core_clk) disable iff (!reset_n)
    req.op == op_add
    |=> status_r[bit_zero] == (($past(req.opa) + $past(req.opb)) == 8'h00))
    else $error("zero flag wrong");

  // Status reads and writes
  chk_event_bits: assert property (@(posedge core_clk) disable iff (!reset_n)
    (dev_event == '0)
    |=> status_r[4:3] == $past(status_r[4:3]))
    else $error("event bits written");

  chk_status_mirror: assert property (@(posedge core_clk) disable iff (!reset_n)
    (!is_indirect && req.addr[6:0] == status_offset)
    |-> rdata == status_r)
    else $error("status mirror");

  chk_flag_block: assert property (@(posedge core_clk) disable iff (!reset_n)
    (req.op == op_logic && !req.carry_in_en)
    |=> status_r[1:0] == $past(status_r[1:0]))
    else $error("flag write not blocked");

  chk_status_write_mask: assert property (@(posedge core_clk) disable iff (!reset_n)
    (req.wr_en && !is_indirect && req.addr[6:0] == status_offset && req.op == op_none && dev_event == '0)
    |=> status_r == (($past(status_r) & event_flag_mask) | ($past(req.wdata) & ~event_flag_mask)))
    else $error("status write mask wrong");

  // Scenario covers
  cov_indirect: cover property (@(posedge core_clk)
    is_indirect && !self_ref);
  cov_self: cover property (@(posedge core_clk)
    self_ref && req.wr_en);
  cov_bank1: cover property (@(posedge core_clk)
    !is_indirect && status_r[bit_direct_bank_low]);
  cov_sub: cover property (@(posedge core_clk)
    req.op == op_sub);
  cov_logic_status: cover property (@(posedge core_clk)
    req.op == op_logic && req.wr_en && !is_indirect && req.addr[6:0] == status_offset);
endmodule
`default_nettype wire

// file: test/file_ram_model.sv
`timescale 1ns/1ps
`default_nettype none
module file_ram_model (
  input wire logic core_clk,
  input wire logic [8:0] mem_addr,
  input wire logic mem_sel,
  input wire logic mem_wr_en,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata
);
  logic [7:0] ram [0:511];
  logic [7:0] last_r = 8'h5a;
  always_ff @(posedge core_clk) begin
    if (mem_sel && mem_wr_en) begin
      ram[mem_addr] <= mem_wdata;
    end
    if (mem_sel) begin
      last_r <= ram[mem_addr];
    end
  end
  // Unselected: inverse of last value, never a stale match
  assign mem_rdata = mem_sel ? ram[mem_addr] : ~last_r;
endmodule
`default_nettype wire

// file: test/status_indirect_tb.sv
`timescale 1ns/1ps
`default_nettype none
module status_indirect_tb;
  import status_indirect_pkg::*;
  `define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin failures++; \
    $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  core_req_s req;
  dev_event_s dev_event;
  logic [7:0] mem_rdata, mem_wdata, rdata, alu_result, status_out, pointer_out;
  logic [8:0] mem_addr;
  logic mem_sel, mem_wr_en;
  int failures = 0;
  int n_tests = 0;
  int cycles = 0;
  alu_op_e ops [5] = '{op_add, op_add, op_sub, op_sub, op_sub};
  logic [7:0] xa [5] = '{8'hff, 8'h01, 8'h05, 8'h03, 8'h10};
  logic [7:0] xb [5] = '{8'h01, 8'h01, 8'h03, 8'h05, 8'h01};
  logic [7:0] ex [5] = '{8'h1f, 8'h18, 8'h1b, 8'h18, 8'h19};
  always #5 core_clk = ~core_clk;
  status_indirect u_dut (.core_clk(core_clk), .reset_n(reset_n), .req(req), .dev_event(dev_event),
    .mem_rdata(mem_rdata), .mem_addr(mem_addr), .mem_sel(mem_sel), .mem_wr_en(mem_wr_en),
    .mem_wdata(mem_wdata), .rdata(rdata), .alu_result(alu_result), .status_out(status_out),
    .pointer_out(pointer_out));
  file_ram_model u_ram (.core_clk(core_clk), .mem_addr(mem_addr), .mem_sel(mem_sel),
    .mem_wr_en(mem_wr_en), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
  task automatic go(input logic w, input logic [7:0] a, input logic [7:0] d, input alu_op_e o,
                    input logic [7:0] x, input logic [7:0] y);
    req = {w, a, d, o, x, y, 2'b00};
    #1;
  endtask
  task automatic tick();
    @(posedge core_clk);
    #1;
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 300) begin
      failures++;
      summarize();
    end
  end
  initial begin
    req = {1'b0, 8'h00, 8'h00, op_none, 16'h0000, 2'b00};
    dev_event = 4'h0;
    repeat (4) @(posedge core_clk);
    #1 reset_n = 1'b1;
    `CHK("status reset", 8'h18, status_out)
    `CHK("pointer reset", 8'h00, pointer_out)
    go(1'b1, 8'h05, 8'h10, op_none, 8'h00, 8'h00);
    `CHK("direct addr", 9'h005, mem_addr)
    tick();
    go(1'b1, 8'h04, 8'h05, op_none, 8'h00, 8'h00);
    tick();
    go(1'b0, 8'h00, 8'h00, op_none, 8'h00, 8'h00);
    `CHK("indirect addr", 9'h005, mem_addr)
    `CHK("indirect read", 8'h10, rdata)
    go(1'b1, 8'h04, 8'h00, op_none, 8'h00, 8'h00);
    tick();
    go(1'b1, 8'h00, 8'h55, op_none, 8'h00, 8'h00);
    `CHK("self write", 1'b0, mem_wr_en)
    tick();
    `CHK("self pointer", 8'h00, pointer_out)
    go(1'b0, 8'h00, 8'h00, op_none, 8'h00, 8'h00);
    `CHK("self read", 8'h00, rdata)
    $display("test indirect done");
    go(1'b1, 8'h03, 8'h20, op_none, 8'h00, 8'h00);
    tick();
    `CHK("status bank1", 8'h38, status_out)
    go(1'b1, 8'h05, 8'haa, op_none, 8'h00, 8'h00);
    `CHK("bank1 addr", 9'h085, mem_addr)
    tick();
    go(1'b1, 8'h83, 8'h00, op_none, 8'h00, 8'h00);
    tick();
    `CHK("status alias", 8'h18, status_out)
    $display("test banks done");
    for (int i = 0; i < 5; i++) begin
      go(1'b0, 8'h10, 8'h00, ops[i], xa[i], xb[i]);
      tick();
      `CHK("flags", ex[i], status_out)
    end
    go(1'b1, 8'h03, 8'h07, op_add, 8'h08, 8'h08);
    `CHK("alu sum", 8'h10, alu_result)
    tick();
    `CHK("flag write", 8'h1a, status_out)
    $display("test flags done");
    go(1'b0, 8'h10, 8'h00, op_none, 8'h00, 8'h00);
    dev_event = 4'h5;
    tick();
    `CHK("events clear", 8'h02, status_out)
    dev_event = 4'hf;
    tick();
    `CHK("events set", 8'h1a, status_out)
    dev_event = 4'h0;
    $display("test events done");
    go(1'b0, 8'h10, 8'h00, op_logic, 8'h00, 8'h00);
    `CHK("logic result", 8'h00, alu_result)
    tick();
    `CHK("logic zero", 8'h1e, status_out)
    go(1'b1, 8'h03, 8'h03, op_logic, 8'h00, 8'h00);
    tick();
    `CHK("logic flag block", 8'h1a, status_out)
    $display("test logic done");
    summarize();
  end
endmodule
`default_nettype wire
